// ### hw/baud_gen.sv
// Conventional transmit and receive baud tick generator
`timescale 1ns/10ps
`include "lin_params.svh"
`default_nettype none
module baud_gen (
  input  wire logic              pclk,    // Clock
  input  wire logic              presetn, // Async reset, active low
  input  wire logic              tx_en,   // Transmit rate running
  input  wire logic              rx_en,   // Receive rate running
  input  wire lin_pkg::baud_sel_t sel,    // Prescaler and divider selects
  output logic                   tx_tick, // One pulse per transmit bit
  output logic                   rx_tick  // One pulse per receive bit
);
  import lin_pkg::*;
  baud_state_t s_reg;
  baud_state_t s_next;
  logic        base_end;

  // Sixteen times the shared prescaler value
  function automatic logic [7:0] psc16(input logic [1:0] c);
    case (c)
      2'h0:    psc16 = `PSC_CODE0;
      2'h1:    psc16 = `PSC_CODE1;
      2'h2:    psc16 = `PSC_CODE2;
      default: psc16 = `PSC_CODE3;
    endcase
  endfunction

  // Last count of a power-of-two divider, 1 to 128
  function automatic logic [6:0] div_top(input logic [2:0] c);
    div_top = 7'h7f >> (3'h7 - c);
  endfunction

  // Shared stage then independent dividers
  always_comb begin
    s_next = s_reg;
    base_end = (s_reg.base == psc16(sel.psc) - 8'h01);
    s_next.txt = 1'b0;
    s_next.rxt = 1'b0;
    if (!(tx_en || rx_en)) begin
      s_next.base = 8'h00;
    end else begin
      s_next.base = base_end ? 8'h00 : s_reg.base + 8'h01;
    end
    if (!tx_en) begin
      s_next.txc = 7'h00;
    end else if (base_end) begin
      s_next.txt = (s_reg.txc == div_top(sel.tx));
      s_next.txc = s_next.txt ? 7'h00 : s_reg.txc + 7'h01;
    end
    if (!rx_en) begin
      s_next.rxc = 7'h00;
    end else if (base_end) begin
      s_next.rxt = (s_reg.rxc == div_top(sel.rx));
      s_next.rxc = s_next.rxt ? 7'h00 : s_reg.rxc + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tx_tick = s_reg.txt;
  assign rx_tick = s_reg.rxt;

  // Transmit ticks never come on two cycles in a row
  tick_space_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_tick |=> !tx_tick) else $error("tx tick repeated back to back");
endmodule // baud_gen
`default_nettype wire

// ### hw/lin_params.svh
// Register map, field positions and timing constants of the LIN slave header block
`ifndef LIN_PARAMS_SVH
`define LIN_PARAMS_SVH
`define A_STATUS     8'h00
`define A_BAUD       8'h04
`define A_ETPR       8'h08
`define A_CTRL3      8'h0c
`define A_CTRL       8'h10
`define A_HLEN       8'h14
`define ST_FE        0
`define ST_HE        1
`define C3_LSF       0
`define C3_HDF       1
`define C3_HIE       2
`define C3_ASE       3
`define C3_HDM       4
`define C3_LIN       5
`define CT_RWU       0
`define CT_TXEN      1
`define CT_RXEN      2
`define BR_PSC_HI    7
`define BR_PSC_LO    6
`define BR_TX_HI     5
`define BR_TX_LO     3
`define BR_RX_HI     2
`define BR_RX_LO     0
`define BRK_MIN      5'h0b
`define STOP_IDX     5'h09
`define HDR_MAX      8'h39
`define SYNCH_BYTE   8'h55
`define SYNCH_EDGES  3'h5
`define PSC_CODE0    8'h10
`define PSC_CODE1    8'h30
`define PSC_CODE2    8'h40
`define PSC_CODE3    8'hd0
`endif

// ### hw/lin_pkg.sv
// Types shared by the LIN slave header block and its helpers
`default_nettype none
package lin_pkg;
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_BRK  = 4'b0010,
    HS_SYN  = 4'b0100,
    HS_IDN  = 4'b1000
  } hdr_state_t;

  typedef struct packed {
    logic [1:0] psc;
    logic [2:0] tx;
    logic [2:0] rx;
  } baud_sel_t;

  typedef struct packed {
    logic [7:0] base;
    logic [6:0] txc;
    logic [6:0] rxc;
    logic       txt;
    logic       rxt;
  } baud_state_t;

  typedef struct packed {
    logic [1:0] sync;
  } sync_state_t;

  typedef struct packed {
    hdr_state_t  st;
    logic        go;
    logic        rx_d;
    logic [4:0]  k;
    logic [4:0]  lowcnt;
    logic [11:0] phase;
    logic [7:0]  hlen;
    logic        hlen_on;
    logic [7:0]  shreg;
    logic [2:0]  fedges;
    logic        fe;
    logic        he;
    logic        hdf;
    logic        synch_field_state;
    logic        hie;
    logic        hdm;
    logic        ase;
    logic        lin_mode;
    logic [7:0]  mant;
    logic [3:0]  frac;
    baud_sel_t   brr;
    logic [7:0]  etpr;
    logic        receiver_wakeup_request;
    logic        txen;
    logic        rxen;
    logic        seq;
    logic [7:0]  header_length_value;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        irq;
  } core_state_t;
endpackage
`default_nettype wire

// ### hw/lin_slave_header_baud.sv
// LIN slave header detector, mute wake-up and baud generation with APB registers
//
// Operation
// - Header error outside synch field, or without auto-sync, drops header; seek new break.
// - Time-out only when header length exceeds 57 slave bit periods.
// - Header length readable only with identifier detection or auto-sync enabled.
// - Muted identifier mode: synch error or time-out flags error, no wake, drops.
// - While muted, data framing errors are discarded; framing flag stays clear.
// - Identifier mode wakes only on full valid header without time-out.
// - Detect method bit replaces wake bit: 0 break, 1 identifier.
// - Interrupt raised while LIN mode on, header flag set and header interrupt enabled.
// - Header flag set on detection; cleared by status access then control three read.
// - Method 0 detects on break; method 1 after break, synch, identifier.
// - Synch state bit set on break, cleared when done; software may clear.
// - In synch state with auto-sync, falling receive edges are counted.
// - Mantissa at baud address, fraction at extended transmit prescaler address.
// - Mantissa 00h stops serial clock; 01h..FFh give 1..255.
// - Outside LIN mode, Tx and Rx rates are clock over 16, prescaler, own divider; LIN mode stops both.
// - Wake-up request mutes receiver and blocks the framing error bit, not the header interrupt.
`timescale 1ns/10ps
`include "lin_params.svh"
`default_nettype none
module lin_slave_header_baud (
  input  wire logic        pclk,       // Clock, 250 MHz
  input  wire logic        presetn,    // Async reset, active low
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB enable
  input  wire logic        pwrite,     // APB write
  input  wire logic [7:0]  paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic [31:0]      prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error on unmapped address
  input  wire logic        receive_data_in, // LIN receive pin
  output logic             serial_irq, // Header interrupt
  output logic             muted,      // Receiver in mute mode
  output logic             tx_tick,    // Transmit bit tick
  output logic             rx_tick     // Receive bit tick
);
  import lin_pkg::*;
  core_state_t s_reg;
  core_state_t s_next;
  logic        rx;
  logic        fall;
  logic        samp;
  logic        bit_end;
  logic        take;
  logic        clr_seq;
  logic        hdf_set;
  logic        hlen_vis;
  logic [11:0] per;
  logic [7:0]  hlen_inc;

  rx_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (receive_data_in),
    .level   (rx)
  );

  baud_gen u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .tx_en   (s_reg.txen && !s_reg.lin_mode),
    .rx_en   (s_reg.rxen && !s_reg.lin_mode),
    .sel     (s_reg.brr),
    .tx_tick (tx_tick),
    .rx_tick (rx_tick)
  );

  // Bus handling, then bit timing and header sequencing; sets come after clears
  always_comb begin
    s_next   = s_reg;
    per      = {s_reg.mant, s_reg.frac};              // Slave bit period in clocks
    fall     = s_reg.rx_d && !rx;
    bit_end  = (s_reg.phase == per - 12'h001);
    samp     = s_reg.go && (s_reg.phase == {1'b0, per[11:1]});
    take     = psel && penable && s_reg.ready;
    clr_seq  = take && !pwrite && (paddr == `A_CTRL3) && s_reg.seq;
    hdf_set  = 1'b0;
    hlen_vis = s_reg.hdm || s_reg.ase;
    hlen_inc = s_reg.hlen + 8'h01;
    s_next.rx_d   = rx;
    s_next.ready  = psel && penable && !s_reg.ready;
    s_next.slverr = 1'b0;
    // Read data is captured at the same edge that raises pready
    if (psel && penable && !s_reg.ready) begin
      s_next.rdata = 32'h0000_0000;
      case (paddr)
        `A_STATUS: begin
          s_next.rdata[`ST_FE] = s_reg.fe;
          s_next.rdata[`ST_HE] = s_reg.he;
        end
        `A_BAUD:  s_next.rdata[7:0] = s_reg.lin_mode ? s_reg.mant : s_reg.brr;
        `A_ETPR:  s_next.rdata[7:0] = s_reg.lin_mode ? {4'h0, s_reg.frac} : s_reg.etpr;
        `A_CTRL3: s_next.rdata[5:0] = {s_reg.lin_mode, s_reg.hdm, s_reg.ase,
                                       s_reg.hie, s_reg.hdf, s_reg.synch_field_state};
        `A_CTRL:  s_next.rdata[2:0] = {s_reg.rxen, s_reg.txen, s_reg.receiver_wakeup_request};
        `A_HLEN:  s_next.rdata[7:0] = hlen_vis ? s_reg.header_length_value : 8'h00;
        default:  s_next.slverr = 1'b1;
      endcase
    end
    // Status access arms the clear; control three read completes it
    if (take && (paddr == `A_STATUS)) begin
      s_next.seq = 1'b1;
    end
    if (clr_seq) begin
      s_next.hdf = 1'b0;
      s_next.he  = 1'b0;
      s_next.fe  = 1'b0;
      s_next.seq = 1'b0;
    end
    // Register writes land at the edge that sees pready
    if (take && pwrite) begin
      case (paddr)
        `A_BAUD: begin
          if (s_reg.lin_mode) begin
            s_next.mant = pwdata[7:0];
          end else begin
            s_next.brr.psc = pwdata[`BR_PSC_HI:`BR_PSC_LO];
            s_next.brr.tx  = pwdata[`BR_TX_HI:`BR_TX_LO];
            s_next.brr.rx  = pwdata[`BR_RX_HI:`BR_RX_LO];
          end
        end
        `A_ETPR: begin
          if (s_reg.lin_mode) begin
            s_next.frac = pwdata[3:0];
          end else begin
            s_next.etpr = pwdata[7:0];
          end
        end
        `A_CTRL3: begin
          s_next.synch_field_state      = s_reg.synch_field_state && pwdata[`C3_LSF]; // Software may only clear
          s_next.hie      = pwdata[`C3_HIE];
          s_next.ase      = pwdata[`C3_ASE];
          s_next.hdm      = pwdata[`C3_HDM];
          s_next.lin_mode = pwdata[`C3_LIN];
        end
        `A_CTRL: begin
          s_next.receiver_wakeup_request  = pwdata[`CT_RWU];
          s_next.txen = pwdata[`CT_TXEN];
          s_next.rxen = pwdata[`CT_RXEN];
        end
        default: ;
      endcase
    end
    // Bit timer resynchronises on each character start
    if (s_reg.go || s_reg.hlen_on) begin
      s_next.phase = bit_end ? 12'h000 : s_reg.phase + 12'h001;
    end
    case (s_reg.st)
      HS_IDLE: begin
        // Mantissa zero leaves the serial clock stopped
        if (fall && s_reg.lin_mode && (s_reg.mant != 8'h00)) begin
          s_next.st      = HS_BRK;
          s_next.go      = 1'b1;
          s_next.phase   = 12'h000;
          s_next.k       = 5'h00;
          s_next.lowcnt  = 5'h00;
          s_next.hlen    = 8'h00;
          s_next.hlen_on = 1'b1;
        end
      end
      HS_BRK: begin
        if (samp) begin
          s_next.k = (s_reg.k == 5'h1f) ? s_reg.k : s_reg.k + 5'h01;
          if ((s_reg.lowcnt == s_reg.k) && !rx) begin
            s_next.lowcnt = (s_reg.lowcnt == 5'h1f) ? s_reg.lowcnt : s_reg.lowcnt + 5'h01;
          end else if ((s_reg.lowcnt == s_reg.k) && (s_reg.lowcnt >= `BRK_MIN)) begin
            // Break of enough dominant bits ended by a recessive bit
            s_next.st  = HS_SYN;
            s_next.go  = 1'b0;
            s_next.synch_field_state = 1'b1;
            if (!s_reg.hdm) begin
              hdf_set    = 1'b1;
              s_next.receiver_wakeup_request = 1'b0;
            end
          end else if ((s_reg.lowcnt == s_reg.k) && (s_reg.k > `STOP_IDX)) begin
            // Low stop bit but too short for a break
            s_next.fe      = s_next.fe || !s_reg.receiver_wakeup_request;
            s_next.st      = HS_IDLE;
            s_next.go      = 1'b0;
            s_next.hlen_on = 1'b0;
          end else if (s_reg.k == `STOP_IDX) begin
            // Ordinary character ends at its stop bit
            s_next.fe      = s_next.fe || (!rx && !s_reg.receiver_wakeup_request);
            s_next.st      = HS_IDLE;
            s_next.go      = 1'b0;
            s_next.hlen_on = 1'b0;
          end
        end
      end
      default: begin
        // Synch and identifier fields share one character receiver
        if (!s_reg.go && fall) begin
          s_next.go     = 1'b1;
          s_next.phase  = 12'h000;
          s_next.k      = 5'h00;
          s_next.fedges = 3'h1;
        end else if (s_reg.go && fall && s_reg.ase && (s_reg.st == HS_SYN)) begin
          s_next.fedges = s_reg.fedges + 3'h1;
        end
        if (samp) begin
          s_next.k = s_reg.k + 5'h01;
          if ((s_reg.k != 5'h00) && (s_reg.k < `STOP_IDX)) begin
            s_next.shreg = {rx, s_reg.shreg[7:1]};
          end
        end
        if (samp && (s_reg.k == `STOP_IDX)) begin
          s_next.go = 1'b0;
          if (s_reg.st == HS_SYN) begin
            if (rx && (s_reg.shreg == `SYNCH_BYTE)
                && (!s_reg.ase || (s_reg.fedges == `SYNCH_EDGES))) begin
              s_next.st  = HS_IDN;
              s_next.synch_field_state = 1'b0;
            end else begin
              s_next.he = 1'b1;
              if (!s_reg.ase || (s_reg.receiver_wakeup_request && s_reg.hdm)) begin
                s_next.st      = HS_IDLE;
                s_next.synch_field_state     = 1'b0;
                s_next.hlen_on = 1'b0;
              end
            end
          end else if (!rx) begin
            s_next.he      = 1'b1;                    // Identifier framing error
            s_next.st      = HS_IDLE;
            s_next.hlen_on = 1'b0;
          end else begin
            s_next.st      = HS_IDLE;
            s_next.hlen_on = 1'b0;
            s_next.header_length_value     = s_reg.hlen;
            if (s_reg.hdm) begin
              hdf_set    = 1'b1;
              s_next.receiver_wakeup_request = 1'b0;
            end
          end
        end
        // Software leaving the synch state returns to idle
        if ((s_reg.st == HS_SYN) && !s_next.synch_field_state && (s_next.st == HS_SYN)) begin
          s_next.st      = HS_IDLE;
          s_next.go      = 1'b0;
          s_next.hlen_on = 1'b0;
        end
      end
    endcase
    // Header length in slave bit periods; exceeding the limit aborts
    if (s_reg.hlen_on && bit_end && (s_next.st != HS_IDLE)) begin
      s_next.hlen = (s_reg.hlen == 8'hff) ? s_reg.hlen : hlen_inc;
      if (hlen_inc > `HDR_MAX) begin
        s_next.he      = 1'b1;
        s_next.st      = HS_IDLE;
        s_next.go      = 1'b0;
        s_next.synch_field_state     = 1'b0;
        s_next.hlen_on = 1'b0;
        s_next.receiver_wakeup_request     = s_reg.receiver_wakeup_request;                   // No wake on time-out
        hdf_set        = 1'b0;
        s_next.header_length_value     = s_reg.header_length_value;
      end
    end
    if (hdf_set) begin
      s_next.hdf = 1'b1;                              // Set wins over clear
    end
    s_next.irq = s_next.lin_mode && s_next.hie && s_next.hdf;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg       <= '0;
      s_reg.st    <= HS_IDLE;
      s_reg.rx_d  <= 1'b1;
      s_reg.shreg <= 8'h00;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata     = s_reg.rdata;
  assign pready     = s_reg.ready;
  assign pslverr    = s_reg.slverr;
  assign serial_irq = s_reg.irq;
  assign muted      = s_reg.receiver_wakeup_request;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence status_then_ctrl3;
    s_reg.seq ##0 (take && !pwrite && paddr == `A_CTRL3);
  endsequence

  timeout_fire_a: assert property ((s_reg.hlen_on && bit_end && s_reg.hlen == `HDR_MAX
    && s_reg.st != HS_IDLE) |=> (s_reg.he && s_reg.st == HS_IDLE))
    else $error("time-out missing after limit");
  lhl_bound_a: assert property (s_reg.header_length_value <= `HDR_MAX)
    else $error("header length above limit");
  hlen_gate_a: assert property ((psel && penable && !s_reg.ready && !pwrite
    && paddr == `A_HLEN && !s_reg.hdm && !s_reg.ase) |=> (prdata == 32'h0000_0000))
    else $error("header length visible when gated");
  fe_mute_a: assert property ($rose(s_reg.fe) |-> !$past(s_reg.receiver_wakeup_request))
    else $error("framing error set while muted");
  wake_idn_a: assert property (($fell(s_reg.receiver_wakeup_request) && s_reg.hdm && !$past(take && pwrite))
    |-> ($past(s_reg.st) == HS_IDN && s_reg.hdf))
    else $error("wake-up without full header");
  irq_follow_a: assert property (serial_irq ==
    (s_reg.lin_mode && s_reg.hie && s_reg.hdf))
    else $error("interrupt does not follow flag");
  hdf_clear_a: assert property ((status_then_ctrl3 ##0 !hdf_set) |=> !s_reg.hdf)
    else $error("header flag not cleared");
  drop_idle_a: assert property (($rose(s_reg.he)
    && (!s_reg.ase || $past(s_reg.st) != HS_SYN)) |-> s_reg.st == HS_IDLE)
    else $error("header kept after error");
  mant_stop_a: assert property ((s_reg.mant == 8'h00 && s_reg.st == HS_IDLE)
    |=> s_reg.st == HS_IDLE) else $error("receiver ran with clock stopped");
endmodule // lin_slave_header_baud
`default_nettype wire

// ### hw/rx_sync.sv
// Two-stage synchroniser for the receive data pin
`timescale 1ns/10ps
`default_nettype none
module rx_sync (
  input  wire logic pclk,    // Clock
  input  wire logic presetn, // Async reset, active low
  input  wire logic pin,     // Raw pin level
  output logic      level    // Synchronised level
);
  import lin_pkg::*;
  sync_state_t s_reg;
  sync_state_t s_next;

  // Shift the pin through two flops; idle line is high
  always_comb begin
    s_next = s_reg;
    s_next.sync = {s_reg.sync[0], pin};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.sync[1];
endmodule // rx_sync
`default_nettype wire

// ### test/lin_master_model.sv
// LIN master model that drives break, synch and identifier fields onto the line
`timescale 1ns/10ps
`default_nettype none
module lin_master_model #(
  parameter int P = 16 // Bit period in clocks
) (
  input  wire logic pclk, // Clock
  output logic      rxd   // Bus level, recessive high
);
  // Recessive while no frame is sent
  initial rxd = 1'b1;
  // One bit held for a whole period, changed just after an edge
  task automatic bit_out(input logic v);
    rxd <= v;
    repeat (P) @(posedge pclk);
  endtask
  // Break of n dominant bits closed by a recessive delimiter
  task automatic brk(input int n);
    repeat (n) bit_out(1'b0);
    bit_out(1'b1);
  endtask
  // Start bit, data lsb first, then a stop bit that may be broken on purpose
  task automatic chr(input logic [7:0] b, input logic stop);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(b[i]);
    bit_out(stop);
    // A broken stop bit is followed by one recessive bit to free the line
    if (!stop) bit_out(1'b1);
  endtask
endmodule // lin_master_model
`default_nettype wire

// ### test/tb_lin_slave_header_baud.sv
// Self-checking bench for the LIN slave header and baud block
`timescale 1ns/10ps
`include "lin_params.svh"
`default_nettype none
module tb_lin_slave_header_baud;
  import lin_pkg::*;
  localparam int P = 16; // Mantissa 1, fraction 0
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]  paddr, id;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rxd, serial_irq, muted, tx_tick, rx_tick;
  logic [2:0]  ts, rs;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          p;

  lin_slave_header_baud dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receive_data_in(rxd),
    .serial_irq(serial_irq), .muted(muted), .tx_tick(tx_tick), .rx_tick(rx_tick)
  );
  lin_master_model #(.P(P)) m (.pclk(pclk), .rxd(rxd));

  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Cut a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // APB transfer; pready, read data and error taken at the rising edge that ends it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Status access followed by a control three read
  task automatic clr_flags();
    apb(1'b0, `A_STATUS, 32'h0);
    apb(1'b0, `A_CTRL3, 32'h0);
  endtask

  // Prescaler value for a select code
  function automatic int pr_of(input logic [1:0] c);
    return c == 2'h0 ? 1 : c == 2'h1 ? 3 : c == 2'h2 ? 4 : 13;
  endfunction

  // Clocks between two ticks of the chosen rate
  task automatic period(input logic t, output int n);
    n = 0;
    do @(negedge pclk); while ((t ? tx_tick : rx_tick) !== 1'b1);
    do begin
      @(negedge pclk);
      n++;
    end while ((t ? tx_tick : rx_tick) !== 1'b1);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'hd31f));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and the unmapped hole
    for (int a = 0; a < 8'h1c; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      chk(rd, 32'h0);
      chk(err, a == 8'h18);
    end
    $display("test reset done");
    // Every prescaler code with random dividers
    for (int c = 0; c < 4; c++) begin
      ts = 3'($urandom % 3);
      rs = 3'($urandom % 3);
      apb(1'b1, `A_CTRL, 32'h0);
      apb(1'b1, `A_BAUD, {24'h0, c[1:0], ts, rs});
      apb(1'b0, `A_BAUD, 32'h0);
      chk(rd, {24'h0, c[1:0], ts, rs});
      apb(1'b1, `A_CTRL, 32'h6);
      period(1'b1, p);
      chk(p, (16 * pr_of(c[1:0])) << ts);
      period(1'b0, p);
      chk(p, (16 * pr_of(c[1:0])) << rs);
    end
    $display("test baud done");
    // Zero mantissa keeps the header logic still
    apb(1'b1, `A_CTRL, 32'h0);
    apb(1'b1, `A_CTRL3, 32'h24);
    apb(1'b1, `A_BAUD, 32'h0);
    m.brk(13);
    chk(serial_irq, 1'b0);
    apb(1'b1, `A_BAUD, 32'h1);
    apb(1'b1, `A_ETPR, 32'h0);
    apb(1'b0, `A_BAUD, 32'h0);
    chk(rd, 32'h1);
    // Method 0: header on break, flag cleared only by the full sequence
    m.brk(13);
    repeat (4) @(posedge pclk);
    chk(serial_irq, 1'b1);
    apb(1'b0, `A_CTRL3, 32'h0);
    chk(rd, 32'h27);
    apb(1'b0, `A_CTRL3, 32'h0);
    chk(rd, 32'h27);
    clr_flags();
    apb(1'b0, `A_CTRL3, 32'h0);
    chk(rd, 32'h25);
    chk(serial_irq, 1'b0);
    apb(1'b1, `A_CTRL3, 32'h24);
    apb(1'b0, `A_CTRL3, 32'h0);
    chk(rd, 32'h24);
    apb(1'b0, `A_HLEN, 32'h0);
    chk(rd, 32'h0);
    $display("test method0 done");
    // Method 1 muted: full header wakes
    apb(1'b1, `A_CTRL3, 32'h3c);
    apb(1'b1, `A_CTRL, 32'h1);
    @(posedge pclk);
    chk(muted, 1'b1);
    id = 8'($urandom);
    m.brk(13);
    m.chr(8'h55, 1'b1);
    m.chr(id, 1'b1);
    repeat (P) @(posedge pclk);
    chk(muted, 1'b0);
    chk(serial_irq, 1'b1);
    apb(1'b0, `A_HLEN, 32'h0);
    chk(rd >= 30 && rd <= 36, 1'b1);
    clr_flags();
    apb(1'b0, `A_CTRL3, 32'h0);
    chk(rd, 32'h3c);
    $display("test method1 done");
    // Muted: bad synch stays muted, framing error on data discarded
    apb(1'b1, `A_CTRL, 32'h1);
    m.brk(13);
    m.chr(8'h54, 1'b1);
    m.chr(8'h00, 1'b0);
    repeat (P) @(posedge pclk);
    chk(muted, 1'b1);
    chk(serial_irq, 1'b0);
    apb(1'b0, `A_STATUS, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, `A_CTRL, 32'h0);
    // Awake again: a broken stop bit now raises the framing flag
    m.chr(8'h00, 1'b0);
    apb(1'b0, `A_STATUS, 32'h0);
    chk(rd, 32'h3);
    $display("test mute errors done");
    // Header length each side of the time-out limit
    for (int g = 20; g <= 30; g += 10) begin
      clr_flags();
      apb(1'b1, `A_CTRL3, 32'h3c);
      m.brk(13);
      m.chr(8'h55, 1'b1);
      repeat (g * P) @(posedge pclk);
      m.chr(id, 1'b1);
      repeat (P) @(posedge pclk);
      chk(serial_irq, g == 20);
      apb(1'b0, `A_STATUS, 32'h0);
      chk(rd, g == 30 ? 32'h2 : 32'h0);
    end
    $display("test timeout done");
    finish_test();
  end
endmodule // tb_lin_slave_header_baud
`default_nettype wire
